// file: include/irq_enable_cfg.svh
// Contract
// - With priority levels off, no request passes unless global peripheral enable is set.
// - Each source has an enable bit: 1 passes its flag, 0 blocks it.
// - First enable register holds eight sources, parallel port at bit 7 down to timer 1.
// - Small package: bit 7 of first enable register is absent and reads 0.
// - Priority bits matter only with priority levels on; otherwise compatibility mode.
`ifndef IRQ_ENABLE_CFG_SVH
`define IRQ_ENABLE_CFG_SVH

// ==========================================
// register byte addresses
`define ADDR_W             6
`define ADDR_ENABLE_1      6'h00
`define ADDR_ENABLE_2      6'h04
`define ADDR_CONTROL       6'h08
`define ADDR_FLAGS         6'h0c
`define ADDR_EVENT_STATUS  6'h10
`define ADDR_EVENT_MASK    6'h14

// ==========================================
// field positions and masks
`define CTRL_PRIO_BIT      0
`define CTRL_GLOBAL_BIT    1
`define CTRL_WIDTH         2
`define EN1_FULL_MASK      8'hff
`define EN1_SMALL_MASK     8'h7f
`define EN2_MASK           8'hdf
`define STRB_LOW_LANE      0

// ==========================================
// reset values
`define ENABLE_RESET       8'h00
`define CTRL_RESET         2'h0
`define EVENT_RESET        16'h0000

`endif

// file: include/irq_enable_pkg.sv
package irq_enable_pkg;

  typedef logic [7:0] byte_reg_type;

  typedef enum logic [1:0]
  {
    resp_okay   = 2'b00,
    resp_slverr = 2'b10
  } axi_resp_type;

endpackage : irq_enable_pkg

// file: src/irq_enable_bank.sv
`timescale 1ns/1ns
`include "irq_enable_cfg.svh"

module irq_enable_bank
#(
  parameter bit SMALL_PACKAGE = 1'b0
)
(
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write address and data
  input  wire logic [`ADDR_W-1:0]            s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read
  input  wire logic [`ADDR_W-1:0]            s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // peripheral flags, same clock
  input  wire irq_enable_pkg::byte_reg_type  flag_1,
  input  wire irq_enable_pkg::byte_reg_type  flag_2,
  // toward the core
  output logic [15:0]                        peripheral_request,
  output logic                               compatibility_mode,
  output logic                               irq
);

  // ==========================================
  // register state
  irq_enable_pkg::byte_reg_type enable_1_reg;
  irq_enable_pkg::byte_reg_type enable_2_reg;
  logic [`CTRL_WIDTH-1:0]       control_reg;
  logic [15:0]                  event_status_reg;
  logic [15:0]                  event_mask_reg;
  logic [15:0]                  request_prev_reg;
  logic [`ADDR_W-1:0]           aw_addr_reg;
  logic [31:0]                  w_data_reg;
  logic                         w_strb_reg;
  logic                         aw_full_reg;
  logic                         w_full_reg;
  logic [15:0]                  gated_request;

  function automatic logic addr_mapped(input logic [`ADDR_W-1:0] addr);
    addr_mapped = (addr == `ADDR_ENABLE_1) || (addr == `ADDR_ENABLE_2) || (addr == `ADDR_CONTROL) ||
                  (addr == `ADDR_FLAGS) || (addr == `ADDR_EVENT_STATUS) || (addr == `ADDR_EVENT_MASK);
  endfunction : addr_mapped

  // ==========================================
  // write channel
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire do_write  = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire b_done    = s_axi_bvalid & s_axi_bready;
  wire aw_full_next = (aw_full_reg | aw_take) & ~do_write;
  wire w_full_next  = (w_full_reg | w_take) & ~do_write;
  wire bvalid_next  = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire wr_lane      = w_strb_reg;
  wire wr_en_1      = do_write & wr_lane & (aw_addr_reg == `ADDR_ENABLE_1);
  wire wr_en_2      = do_write & wr_lane & (aw_addr_reg == `ADDR_ENABLE_2);
  wire wr_ctrl      = do_write & wr_lane & (aw_addr_reg == `ADDR_CONTROL);
  wire wr_status    = do_write & wr_lane & (aw_addr_reg == `ADDR_EVENT_STATUS);
  wire wr_mask      = do_write & wr_lane & (aw_addr_reg == `ADDR_EVENT_MASK);
  // the small package has no parallel port, so its enable never stores
  wire [7:0] en1_mask = SMALL_PACKAGE ? `EN1_SMALL_MASK : `EN1_FULL_MASK;
  wire [7:0] en1_next = wr_en_1 ? (w_data_reg[7:0] & en1_mask) : enable_1_reg;
  wire [7:0] en2_next = wr_en_2 ? (w_data_reg[7:0] & `EN2_MASK) : enable_2_reg;
  wire [1:0] bresp_next = addr_mapped(aw_addr_reg) ? irq_enable_pkg::resp_okay : irq_enable_pkg::resp_slverr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      aw_full_reg   <= aw_full_next;
      w_full_reg    <= w_full_next;
      if (aw_take)
        aw_addr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_reg  <= s_axi_wdata;
        w_strb_reg  <= s_axi_wstrb[`STRB_LOW_LANE];
      end
      s_axi_awready <= ~aw_full_next & ~bvalid_next;
      s_axi_wready  <= ~w_full_next & ~bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      if (do_write)
        s_axi_bresp <= bresp_next;
    end
  end

  // ==========================================
  // registers and events
  // a new request is an event; set beats a same-cycle write-one clear
  wire [15:0] event_set   = gated_request & ~request_prev_reg;
  wire [15:0] status_clr  = wr_status ? w_data_reg[15:0] : 16'h0000;
  wire [15:0] status_next = (event_status_reg & ~status_clr) | event_set;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_1_reg     <= `ENABLE_RESET;
      enable_2_reg     <= `ENABLE_RESET;
      control_reg      <= `CTRL_RESET;
      event_status_reg <= `EVENT_RESET;
      event_mask_reg   <= `EVENT_RESET;
      request_prev_reg <= `EVENT_RESET;
    end
    else
    begin
      enable_1_reg     <= en1_next;
      enable_2_reg     <= en2_next;
      if (wr_ctrl)
        control_reg    <= w_data_reg[`CTRL_WIDTH-1:0];
      if (wr_mask)
        event_mask_reg <= w_data_reg[15:0];
      event_status_reg <= status_next;
      request_prev_reg <= gated_request;
    end
  end

  irq_gate u_gate
  (
    .aclk                         (aclk),
    .aresetn                      (aresetn),
    .flag_1                       (flag_1),
    .flag_2                       (flag_2),
    .enable_1                     (enable_1_reg),
    .enable_2                     (enable_2_reg),
    .priority_levels_enable       (control_reg[`CTRL_PRIO_BIT]),
    .global_peripheral_irq_enable (control_reg[`CTRL_GLOBAL_BIT]),
    .request                      (gated_request)
  );

  // ==========================================
  // read channel
  wire ar_take     = s_axi_arvalid & s_axi_arready;
  wire rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [7:0] flags_1_view = SMALL_PACKAGE ? (flag_1 & `EN1_SMALL_MASK) : flag_1;
  wire [15:0] rd_word =
    (s_axi_araddr == `ADDR_ENABLE_1)     ? {8'h00, enable_1_reg} :
    (s_axi_araddr == `ADDR_ENABLE_2)     ? {8'h00, enable_2_reg} :
    (s_axi_araddr == `ADDR_CONTROL)      ? {14'h0000, control_reg} :
    (s_axi_araddr == `ADDR_FLAGS)        ? {flag_2 & `EN2_MASK, flags_1_view} :
    (s_axi_araddr == `ADDR_EVENT_STATUS) ? event_status_reg :
    (s_axi_araddr == `ADDR_EVENT_MASK)   ? event_mask_reg : 16'h0000;
  wire [1:0] rresp_next = addr_mapped(s_axi_araddr) ? irq_enable_pkg::resp_okay : irq_enable_pkg::resp_slverr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      if (ar_take)
      begin
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= rresp_next;
      end
    end
  end

  // ==========================================
  // outputs toward the core
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      peripheral_request <= 16'h0000;
      compatibility_mode <= 1'b1;
      irq                <= 1'b0;
    end
    else
    begin
      peripheral_request <= gated_request;
      compatibility_mode <= ~control_reg[`CTRL_PRIO_BIT];
      irq                <= |(status_next & event_mask_reg);
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  compat_gate_a: assert property ((!control_reg[0] && !control_reg[1]) |=> gated_request == 16'h0000)
    else $error("request forwarded with global enable off");
  enable_block_a: assert property (gated_request[7:0] == ($past(flag_1) & $past(enable_1_reg) &
    {8{$past(control_reg[0] | control_reg[1])}}))
    else $error("first bank request does not follow flag and enable");
  second_bank_a: assert property (gated_request[15:8] == ($past(flag_2) & $past(enable_2_reg) &
    {8{$past(control_reg[0] | control_reg[1])}}))
    else $error("second bank request does not follow flag and enable");
  small_bit_a: assert property (SMALL_PACKAGE |-> !enable_1_reg[7] && !peripheral_request[7])
    else $error("absent parallel port enable is set");
  unused_bit_a: assert property (!enable_2_reg[5] && !gated_request[13])
    else $error("unimplemented enable bit is set");
  flag_hold_a: assert property ((control_reg[1] && flag_1[0] && enable_1_reg[0]) ##1 $stable(flag_1[0]) &&
    $stable(enable_1_reg[0]) && $stable(control_reg) |-> ##1 gated_request[0])
    else $error("held flag stopped requesting");
  prio_mode_a: assert property (control_reg[0] |=> (gated_request == ((16'($past(flag_2 & enable_2_reg)) << 8) |
    16'($past(flag_1 & enable_1_reg)))))
    else $error("priority mode still gated by global enable");
  set_wins_a: assert property (event_set != 16'h0000 |=> (event_status_reg & $past(event_set)) == $past(event_set))
    else $error("event lost to clear");
  write_resp_a: assert property (do_write |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing");
  irq_level_a: assert property (##1 irq == |(event_status_reg & $past(event_mask_reg)))
    else $error("interrupt output wrong");

  write_seen_c: cover property (b_done && s_axi_bresp == 2'b00);
  read_seen_c: cover property (s_axi_rvalid && s_axi_rready);
  irq_seen_c: cover property (irq ##1 !irq);
  req_seen_c: cover property (control_reg[1] && gated_request != 16'h0000);

endmodule : irq_enable_bank

// file: src/irq_gate.sv
`timescale 1ns/1ns
`include "irq_enable_cfg.svh"

module irq_gate
(
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // flags and enables
  input  wire irq_enable_pkg::byte_reg_type  flag_1,
  input  wire irq_enable_pkg::byte_reg_type  flag_2,
  input  wire irq_enable_pkg::byte_reg_type  enable_1,
  input  wire irq_enable_pkg::byte_reg_type  enable_2,
  input  wire logic                          priority_levels_enable,
  input  wire logic                          global_peripheral_irq_enable,
  // gated requests
  output logic [15:0]                        request
);

  // ==========================================
  // gating
  // with priority levels on, the core's own high/low enables take over
  wire        forward_ok = priority_levels_enable | global_peripheral_irq_enable;
  wire [15:0] request_next = {flag_2 & enable_2, flag_1 & enable_1} & {16{forward_ok}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      request <= 16'h0000;
    else
      request <= request_next;
  end

endmodule : irq_gate

// file: testbench/flag_source_model.sv
`timescale 1ns/1ns
// ====
// peripheral flag sources
module flag_source_model
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // software-side set and clear
  input  wire logic [7:0] raise_1,
  input  wire logic [7:0] raise_2,
  input  wire logic [7:0] clear_1,
  input  wire logic [7:0] clear_2,
  // flags toward the bank
  output logic [7:0]      flag_1,
  output logic [7:0]      flag_2
);
  // flags stay up until cleared; the bank never clears them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_1 <= 8'h00;
      flag_2 <= 8'h00;
    end
    else
    begin
      flag_1 <= (flag_1 & ~clear_1) | raise_1;
      flag_2 <= (flag_2 & ~clear_2) | raise_2;
    end
  end
endmodule : flag_source_model

// file: testbench/peripheral_irq_enable_bank_tb_top.sv
`timescale 1ns/1ns
`include "irq_enable_cfg.svh"
module peripheral_irq_enable_bank_tb_top;
  // ====
  // signals
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        compatibility_mode, irq;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  flag_1, flag_2, raise_1, raise_2, clear_1, clear_2;
  logic [15:0] peripheral_request, small_request;
  logic [31:0] small_rdata;
  int          errors, checked;
  localparam logic [1:0] ok  = irq_enable_pkg::resp_okay;
  localparam logic [1:0] bad = irq_enable_pkg::resp_slverr;

  irq_enable_bank dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .flag_1, .flag_2, .peripheral_request, .compatibility_mode, .irq);
  // small package variant shares the bus; its answers arrive in the same cycles
  irq_enable_bank #(.SMALL_PACKAGE(1'b1)) dut_small (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(),
    .s_axi_rdata(small_rdata), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .flag_1, .flag_2,
    .peripheral_request(small_request), .compatibility_mode(), .irq());
  flag_source_model far (.aclk, .aresetn, .raise_1, .raise_2, .clear_1, .clear_2, .flag_1, .flag_2);

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ====
  // bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : rdc

  // request path is two flops deep; three edges leave margin
  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle

  task automatic flags(input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] c1);
    @(posedge aclk);
    raise_1 <= r1;
    raise_2 <= r2;
    clear_1 <= c1;
    @(posedge aclk);
    raise_1 <= 8'h00;
    raise_2 <= 8'h00;
    clear_1 <= 8'h00;
    settle();
  endtask : flags

  // ====
  // scenarios
  task automatic reset_and_layout;
    rdc(`ADDR_ENABLE_1, 32'h0, ok);
    rdc(`ADDR_ENABLE_2, 32'h0, ok);
    chk(compatibility_mode, 1'b1);
    wr(`ADDR_ENABLE_1, 32'hffff_ffff, ok);
    rdc(`ADDR_ENABLE_1, {24'h0, `EN1_FULL_MASK}, ok);
    chk(small_rdata, {24'h0, `EN1_SMALL_MASK});
    s_axi_wstrb <= 4'he;
    wr(`ADDR_ENABLE_1, 32'h0, ok);
    s_axi_wstrb <= 4'hf;
    rdc(`ADDR_ENABLE_1, {24'h0, `EN1_FULL_MASK}, ok);
    wr(`ADDR_ENABLE_2, 32'h0000_00ff, ok);
    rdc(`ADDR_ENABLE_2, {24'h0, `EN2_MASK}, ok);
    wr(6'h18, 32'h1, bad);
    rdc(6'h18, 32'h0, bad);
  endtask : reset_and_layout

  task automatic gating;
    flags(8'hff, 8'hff, 8'h00);
    chk(peripheral_request, 16'h0000);
    wr(`ADDR_CONTROL, 32'h2, ok);
    settle();
    chk(peripheral_request, {`EN2_MASK, 8'hff});
    chk(small_request, {`EN2_MASK, `EN1_SMALL_MASK});
    wr(`ADDR_ENABLE_1, 32'h0f, ok);
    settle();
    chk(peripheral_request, {`EN2_MASK, 8'h0f});
    rdc(`ADDR_FLAGS, {16'h0, `EN2_MASK, 8'hff}, ok);
    chk(small_rdata, {16'h0, `EN2_MASK, `EN1_SMALL_MASK});
    wr(`ADDR_CONTROL, 32'h1, ok);
    settle();
    chk(peripheral_request, {`EN2_MASK, 8'h0f});
    chk(compatibility_mode, 1'b0);
  endtask : gating

  task automatic stale_flags;
    wr(`ADDR_ENABLE_2, 32'h0, ok);
    wr(`ADDR_ENABLE_1, 32'h0, ok);
    settle();
    chk(peripheral_request, 16'h0000);
    wr(`ADDR_ENABLE_1, 32'hff, ok);
    settle();
    chk(peripheral_request, 16'h00ff);
    flags(8'h00, 8'h00, 8'hff);
    chk(peripheral_request, 16'h0000);
  endtask : stale_flags

  task automatic events;
    wr(`ADDR_EVENT_MASK, 32'h1, ok);
    wr(`ADDR_EVENT_STATUS, 32'hffff, ok);
    settle();
    chk(irq, 1'b0);
    flags(8'h01, 8'h00, 8'h00);
    chk(irq, 1'b1);
    rdc(`ADDR_EVENT_STATUS, 32'h1, ok);
    wr(`ADDR_EVENT_MASK, 32'h0, ok);
    settle();
    chk(irq, 1'b0);
    wr(`ADDR_EVENT_MASK, 32'h1, ok);
    wr(`ADDR_EVENT_STATUS, 32'h1, ok);
    settle();
    chk(irq, 1'b0);
    rdc(`ADDR_EVENT_STATUS, 32'h0, ok);
  endtask : events

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {raise_1, raise_2, clear_1, clear_2} = 32'h0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    reset_and_layout();
    gating();
    stale_flags();
    events();
    summarize();
  end

  // whole run is under two hundred cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    errors++;
    summarize();
  end
endmodule : peripheral_irq_enable_bank_tb_top
